// ### rtl/byte_wide_io_port.sv
// APB register file and pad control logic of one eight-pin port.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`default_nettype none
`include "gpio_regs.svh"
// Summary of operation
// - Direction bit 0 makes the pin an input with driver off.
// - Direction bit 1 enables the pin's output driver.
// - Reset clears all direction bits, pins start as inputs.
// - Input-level register is read-only and returns pin states.
// - Input-level reads work anytime, also for output pins.
// - General-purpose outputs drive the output-value bit.
// - Output-value reads return the last written value.
// - Reset leaves the output-value register untouched.
// - Pull-up select 1 enables the weak pull-up, 0 disables.
// - Pull-up acts only in GPIO mode with driver off.
// - Alternate-function pins always have pull-up disabled.
// - Reset clears all pull-up select bits.
// - Open-drain: output value 0, direction toggles drive low.
// - Bit n of each register serves pin n only.
// - Function select 0 is GPIO, 1 hands pin to peripheral.
// - Reset clears every function-select bit.
// - All registers are byte-wide writable except input level.
module byte_wide_io_port
	import gpio_pkg::*;
(
	input wire logic pclk, // System clock, 50 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write direction.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error, unmapped address.
	input wire pin_byte_t pin_in, // Pad input levels.
	output pad_ctrl_t pad_ctrl, // Pad drive, enable and pull-up.
	input wire pin_byte_t periph_out, // Peripheral output data.
	input wire pin_byte_t periph_oe // Peripheral drive enable.
);
	pin_byte_t pin_direction;
	pin_byte_t pin_output_value;
	pin_byte_t pin_pullup_select;
	pin_byte_t pin_function_select;
	pin_byte_t pin_input_level;
	pin_byte_t next_direction;
	pin_byte_t next_output_value;
	pin_byte_t next_pullup_select;
	pin_byte_t next_function_select;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic access;
	logic wr_ok;
	reg_sel_t sel;
	wire pin_byte_t pad_value;
	wire pin_byte_t pad_enable;
	wire pin_byte_t pad_pullup;

	// Pin levels are resynchronised before software can see them.
	pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pin_input_level)
	);

	// Address decode; every access completes in its first access cycle.
	always_comb begin
		access = psel && penable;
		unique case (paddr)
			`OFF_PIN_DIRECTION: sel = sel_direction;
			`OFF_PIN_INPUT_LEVEL: sel = sel_input;
			`OFF_PIN_OUTPUT_VALUE: sel = sel_output;
			`OFF_PIN_PULLUP_SELECT: sel = sel_pullup;
			`OFF_PIN_FUNCTION_SELECT: sel = sel_function;
			default: sel = sel_none;
		endcase
		// Only the low lane holds data, so only its strobe counts.
		wr_ok = access && pwrite && pstrb[0];
	end
	// Zero wait states: every register answers in its first access cycle.
	assign pready = 1'b1;

	// Next values of the writable registers.
	always_comb begin
		next_direction = pin_direction;
		next_output_value = pin_output_value;
		next_pullup_select = pin_pullup_select;
		next_function_select = pin_function_select;
		if (wr_ok) begin
			unique case (sel)
				sel_direction: next_direction = pwdata[7:0];
				sel_output: next_output_value = pwdata[7:0];
				sel_pullup: next_pullup_select = pwdata[7:0];
				sel_function: next_function_select = pwdata[7:0];
				sel_input: next_direction = pin_direction;
				sel_none: next_direction = pin_direction;
			endcase
		end
	end

	// Control registers clear at reset; pull-ups and pins start off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction <= `RST_PIN_DIRECTION;
			pin_pullup_select <= `RST_PIN_PULLUP_SELECT;
			pin_function_select <= `RST_PIN_FUNCTION_SELECT;
		end else begin
			pin_direction <= next_direction;
			pin_pullup_select <= next_pullup_select;
			pin_function_select <= next_function_select;
		end
	end

	// Output value has no reset, so a device reset keeps its contents.
	always_ff @(posedge pclk) begin
		pin_output_value <= next_output_value;
	end

	// Read data and error answer, registered for the access cycle.
	always_comb begin
		next_prdata = 32'h00000000;
		next_pslverr = 1'b0;
		if (psel && !penable && !pwrite) begin
			unique case (sel)
				sel_direction: next_prdata = {24'h000000, pin_direction};
				sel_input: next_prdata = {24'h000000, pin_input_level};
				sel_output: next_prdata = {24'h000000, pin_output_value};
				sel_pullup: next_prdata = {24'h000000, pin_pullup_select};
				sel_function: next_prdata = {24'h000000, pin_function_select};
				sel_none: next_prdata = 32'h00000000;
			endcase
		end
		if (psel && !penable) begin
			next_pslverr = (sel == sel_none);
		end
	end

	// Read data is captured in the setup cycle and shown in access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Per-pin pad mux; each bit depends only on its own pin's bits.
	// A peripheral owns its pin outright, so no stray pull-up can load
	// the line while the peripheral drives it.
	for (genvar i = 0; i < `PIN_WIDTH; i++) begin : g_pad
		// Clear out value and toggle direction for open drain.
		assign pad_value[i] = pin_function_select[i] ? periph_out[i]
			: pin_output_value[i];
		assign pad_enable[i] = pin_function_select[i] ? periph_oe[i]
			: pin_direction[i];
		// The pull-up only helps a GPIO pin whose driver is off.
		assign pad_pullup[i] = pin_pullup_select[i] && !pin_direction[i]
			&& !pin_function_select[i];
	end

	// The struct fields are packed in the order value, enable, pull-up.
	assign pad_ctrl = {pad_value, pad_enable, pad_pullup};

	// Helper sequence: a write of the direction register.
	sequence dir_write_s;
		wr_ok && sel == sel_direction;
	endsequence

	dir_write_takes_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		dir_write_s |=> pin_direction == $past(pwdata[7:0]))
	else $error("direction write not stored");

	gpio_drive_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		!pin_function_select[0] |-> pad_ctrl.out_enable[0] == pin_direction[0])
	else $error("driver enable does not follow direction");

	output_drive_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && sel == sel_output && !pin_function_select[1]
		|=> pad_ctrl.out_value[1] == $past(pwdata[1]))
	else $error("output write not driven");

	out_readback_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && sel == sel_output
		|=> prdata[7:0] == $past(pin_output_value))
	else $error("output readback wrong");

	// The first two edges after reset still show the cleared stages.
	input_sync_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) && $past(presetn, 2)
		|-> pin_input_level == $past(pin_in, 2))
	else $error("input level not two-stage synchronised");

	input_ro_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && sel == sel_input |=> $stable(pin_direction)
		&& $stable(pin_pullup_select))
	else $error("input level write changed state");

	pullup_gate_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		pad_ctrl.pullup_enable[2] |-> pin_pullup_select[2]
		&& !pad_ctrl.out_enable[2] && !pin_function_select[2])
	else $error("pull-up active outside gpio input");

	alt_pullup_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		pin_function_select[3] |-> !pad_ctrl.pullup_enable[3])
	else $error("pull-up on alternate pin");

	alt_handover_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		pin_function_select[4] |-> pad_ctrl.out_enable[4] == periph_oe[4]
		&& pad_ctrl.out_value[4] == periph_out[4])
	else $error("peripheral not given the pin");

	reset_state_a:
	assert property (@(posedge pclk) $rose(presetn) |->
		pin_direction == 8'h00 && pin_pullup_select == 8'h00
		&& pin_function_select == 8'h00)
	else $error("control registers not cleared by reset");

	// A read setup of the input-level register; the answer follows.
	sequence input_read_s;
		psel && !penable && !pwrite && sel == sel_input;
	endsequence

	// A setup cycle aimed at no register at all.
	sequence unmapped_s;
		psel && !penable && sel == sel_none;
	endsequence

	// Reset seen low on two edges, so the asynchronous clear has landed.
	sequence in_reset_s;
		!presetn ##1 !presetn;
	endsequence

	// Read answers, reset values and pad behaviour seen from outside.
	// The pad checks pick one pin each; the register checks compare the whole byte.
	input_read_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		input_read_s |=> prdata[7:0] == $past(pin_input_level))
	else $error("input level read wrong");

	dir_readback_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && sel == sel_direction
		|=> prdata[7:0] == $past(pin_direction))
	else $error("direction readback wrong");

	pullup_readback_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && sel == sel_pullup
		|=> prdata[7:0] == $past(pin_pullup_select))
	else $error("pull-up readback wrong");

	unmapped_error_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		unmapped_s |=> pslverr && prdata == 32'h00000000)
	else $error("unmapped access not refused");

	pullup_reset_a:
	assert property (@(posedge pclk)
		in_reset_s |-> pin_pullup_select == `RST_PIN_PULLUP_SELECT)
	else $error("pull-up select not cleared in reset");

	func_reset_a:
	assert property (@(posedge pclk)
		in_reset_s |-> pin_function_select == `RST_PIN_FUNCTION_SELECT)
	else $error("function select not cleared in reset");

	open_drain_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		!pin_function_select[5] && !pin_output_value[5] && pin_direction[5]
		|-> pad_ctrl.out_enable[5] && !pad_ctrl.out_value[5])
	else $error("open drain pin not pulled low");

	pullup_select_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		pin_pullup_select[6] && !pin_direction[6] && !pin_function_select[6]
		|-> pad_ctrl.pullup_enable[6])
	else $error("selected pull-up not enabled");

	access_ready_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable |-> pready)
	else $error("access not answered at once");

	output_store_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && sel == sel_output |=> pin_output_value == $past(pwdata[7:0]))
	else $error("output value write not stored");

	func_write_a:
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && sel == sel_function |=> pin_function_select == $past(pwdata[7:0]))
	else $error("function select write not stored");
endmodule // byte_wide_io_port
`default_nettype wire

// ### rtl/gpio_regs.svh
// Register offsets, reset values and field constants of the byte-wide port.
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
`define PIN_WIDTH 8
`define OFF_PIN_DIRECTION 12'h000
`define OFF_PIN_INPUT_LEVEL 12'h004
`define OFF_PIN_OUTPUT_VALUE 12'h008
`define OFF_PIN_PULLUP_SELECT 12'h00c
`define OFF_PIN_FUNCTION_SELECT 12'h010
`define RST_PIN_DIRECTION 8'h00
`define RST_PIN_PULLUP_SELECT 8'h00
`define RST_PIN_FUNCTION_SELECT 8'h00
`define ADDR_WIDTH 12
`endif

// ### rtl/gpio_pkg.sv
// Types shared by the byte-wide port design.
`default_nettype none
`include "gpio_regs.svh"
package gpio_pkg;
	typedef logic [7:0] pin_byte_t;
	// Per-pin pad control bundle.
	typedef struct packed {
		pin_byte_t out_value;
		pin_byte_t out_enable;
		pin_byte_t pullup_enable;
	} pad_ctrl_t;
	// Register selector decoded from the APB address.
	typedef enum logic [2:0] {
		sel_direction = 3'b000,
		sel_input = 3'b001,
		sel_output = 3'b010,
		sel_pullup = 3'b011,
		sel_function = 3'b100,
		sel_none = 3'b111
	} reg_sel_t;
endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
// Two-stage synchroniser for the eight pin levels.
`default_nettype none
module pin_sync
	import gpio_pkg::*;
(
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire pin_byte_t async_in, // Raw pin levels.
	output logic [7:0] sync_out // Synchronised levels.
);
	pin_byte_t stage1;
	pin_byte_t next_stage1;
	pin_byte_t next_sync;

	// The first stage feeds only the second stage.
	always_comb begin
		next_stage1 = async_in;
		next_sync = stage1;
	end

	// Both stages clear to a constant under reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 8'h00;
			sync_out <= 8'h00;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ### sim/board_model.sv
// Board-side circuitry that resolves the eight port pin levels.
`default_nettype none
module board_model
	import gpio_pkg::*;
(
	input wire logic pclk, // System clock, ages floating pins.
	input wire pad_ctrl_t pad_ctrl, // Drive, enable and pull-up from port.
	input wire logic [7:0] ext_en, // Board drivers enabled.
	input wire logic [7:0] ext_val, // Board driver levels.
	output logic [7:0] pin_in // Resolved pin levels.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Starts low so that an undriven pin toggles from a known level.
	logic [7:0] last = 8'h00;
	// A floating pin flips every cycle, so a stale level never passes.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_ctrl.out_enable[i]) begin
				pin_in[i] = pad_ctrl.out_value[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pad_ctrl.pullup_enable[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = ~last[i];
			end
		end
	end
	// Remember the last resolved level of each pin.
	always_ff @(posedge pclk) begin
		last <= pin_in;
	end
endmodule // board_model
`default_nettype wire

// ### sim/testbench.sv
// Directed testbench for the byte-wide port over APB.
`default_nettype none
`include "gpio_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench
	import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] pin_in, periph_out, periph_oe, ext_en, ext_val;
	pad_ctrl_t pad_ctrl;
	int n_errors = 0;
	int check_count = 0;
	byte_wide_io_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pad_ctrl(pad_ctrl), .periph_out(periph_out),
		.periph_oe(periph_oe));
	board_model i_board (.pclk(pclk), .pad_ctrl(pad_ctrl), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reads after two idle cycles so pin changes pass the synchroniser.
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		repeat (2) @(posedge pclk);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic end_sim();
		if (n_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Watchdog: the tests need only a few microseconds.
	initial begin
		#100us;
		n_errors++;
		end_sim();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		{periph_out, periph_oe} = '0;
		ext_en = 8'hff;
		ext_val = 8'h3c;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`OFF_PIN_DIRECTION, 32'h0);
		rdchk(`OFF_PIN_PULLUP_SELECT, 32'h0);
		rdchk(`OFF_PIN_FUNCTION_SELECT, 32'h0);
		`CHK(pad_ctrl.out_enable, 8'h00)
		rdchk(`OFF_PIN_INPUT_LEVEL, 32'h3c);
		// Upper data bits are outside the byte and must be dropped.
		apb(1'b1, `OFF_PIN_OUTPUT_VALUE, 32'hffff_ffa5);
		apb(1'b1, `OFF_PIN_DIRECTION, 32'h0f);
		ext_en <= 8'hf0;
		@(negedge pclk);
		`CHK(pad_ctrl.out_enable, 8'h0f)
		`CHK(pad_ctrl.out_value, 8'ha5)
		rdchk(`OFF_PIN_OUTPUT_VALUE, 32'ha5);
		rdchk(`OFF_PIN_INPUT_LEVEL, 32'h35);
		apb(1'b1, `OFF_PIN_INPUT_LEVEL, 32'h00);
		rdchk(`OFF_PIN_INPUT_LEVEL, 32'h35);
		// Hand pin 7 to the peripheral with all pull-ups selected.
		apb(1'b1, `OFF_PIN_PULLUP_SELECT, 32'hff);
		ext_en <= 8'h00;
		periph_oe <= 8'h80;
		apb(1'b1, `OFF_PIN_FUNCTION_SELECT, 32'h80);
		@(negedge pclk);
		`CHK(pad_ctrl.pullup_enable, 8'h70)
		`CHK(pad_ctrl.out_enable, 8'h8f)
		`CHK(pad_ctrl.out_value, 8'h25)
		rdchk(`OFF_PIN_INPUT_LEVEL, 32'h75);
		// Open drain on pin 0: output value 0, direction toggled.
		apb(1'b1, `OFF_PIN_OUTPUT_VALUE, 32'h00);
		apb(1'b1, `OFF_PIN_FUNCTION_SELECT, 32'h00);
		periph_oe <= 8'h00;
		apb(1'b1, `OFF_PIN_DIRECTION, 32'h01);
		rdchk(`OFF_PIN_INPUT_LEVEL, 32'hfe);
		apb(1'b1, `OFF_PIN_DIRECTION, 32'h00);
		rdchk(`OFF_PIN_INPUT_LEVEL, 32'hff);
		// A write without the low-lane strobe must leave the byte alone.
		pstrb <= 4'he;
		apb(1'b1, `OFF_PIN_DIRECTION, 32'hff);
		pstrb <= 4'hf;
		rdchk(`OFF_PIN_DIRECTION, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		// A reset in mid-run keeps the output value.
		apb(1'b1, `OFF_PIN_OUTPUT_VALUE, 32'h5a);
		apb(1'b1, `OFF_PIN_FUNCTION_SELECT, 32'h01);
		apb(1'b1, `OFF_PIN_DIRECTION, 32'hff);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`OFF_PIN_OUTPUT_VALUE, 32'h5a);
		rdchk(`OFF_PIN_DIRECTION, 32'h0);
		rdchk(`OFF_PIN_PULLUP_SELECT, 32'h0);
		rdchk(`OFF_PIN_FUNCTION_SELECT, 32'h0);
		end_sim();
	end
endmodule // testbench
`default_nettype wire
